// ===== rtl/cpu_priority_interrupt_unit.v
// What this block does
// - fixed priority: nmi, edge, high, low, general
// - restart vectors 24, 3C, 34, 2C hex
// - push program counter before any vector branch
// - general request branches via supplied bus instruction
// - maskable restart needs enable set, mask clear
// - nmi ignores enable and all masks
// - low restarts are level, sampled like general
// - edge restart latched until serviced, then cleared
// - mask-set write with edge clear bit, or reset, clears edge latch
// - edge latch sets even while masked
// - priority among pending only, no level tracking
// - nmi re-accepted only after low then high
// - nmi saves enable; first mask-read reports it
// - other takes: mask-read shows enable cleared
// - mask-read captures serial in, mask-set drives out
// - sample in next-to-last cycle, finish instruction
// - enable cleared on reset and on accept
// - general ack: strobe on read timing, pc held
`timescale 1ns/1ps
`include "intc_map.vh"
module cpu_priority_interrupt_unit
(
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // request pins, asynchronous
    input wire general_int_request_i,
    input wire restart_lo_i,
    input wire restart_hi_i,
    input wire restart_edge_i,
    input wire nmi_request_i,
    input wire serial_in_line_i,
    // core timing strobes
    input wire sample_slot_i,
    input wire instr_end_i,
    input wire ack_rd_timing_i,
    input wire ack_done_i,
    // core steering outputs
    output reg take_o,
    output reg push_pc_o,
    output reg restart_o,
    output reg [7:0] vector_o,
    output reg pc_inhibit_o,
    output reg int_acknowledge_strobe_o,
    output reg int_enable_o,
    output reg serial_out_line_o
);

// ********************************************
// state encoding
// ********************************************
localparam [2:0] S_IDLE = 3'b001; // nothing chosen
localparam [2:0] S_WAIT = 3'b010; // chosen, instr running
localparam [2:0] S_ACK = 3'b100; // acknowledge cycle

// ********************************************
// declarations
// ********************************************
wire [5:0] pin_w; // raw pins gathered
reg [5:0] s1_r; // first stage, read by s2 only
reg [5:0] s2_r; // second stage
reg [5:0] s3_r; // third stage
reg [5:0] flt_r; // agreed level
wire [5:0] flt_nxt; // next agreed level
wire edge_rise_w; // edge restart rising
reg [2:0] state_r; // one-hot state
reg [2:0] win_r; // chosen request
reg [2:0] mask_r; // restart masks, 1 = masked
reg ie_r; // global enable
reg ie_saved_r; // enable before nmi
reg nmi_seen_r; // nmi taken, not yet read
reg nmi_arm_r; // nmi input was low since take
reg edge_ff_r; // edge restart request latch
reg sout_r; // serial out latch
wire gen_p; // pending general
wire lo_p; // pending low restart
wire hi_p; // pending high restart
wire edge_p; // pending edge restart
wire nmi_p; // pending nmi
wire [2:0] pick_w; // current winner
wire accept_w; // take at end of instr
wire req_w; // new wishbone request
wire wr_w; // write with low lane on
wire rd_w; // read strobe
wire set_w; // mask-set write
wire get_w; // mask-read access
wire ena_w; // enable register write
wire edge_clr_w; // clear of edge latch
wire ie_report_w; // enable as reported
wire ie_nxt; // next global enable
reg [31:0] rdat_nxt; // read mux

// ********************************************
// functions
// ********************************************
// fixed priority among pending requests only;
// the running routine's level is not kept
function [2:0] pick;
    input t;
    input e;
    input h;
    input l;
    input g;
    begin
        if (t)
            pick = `WIN_NMI;
        else if (e)
            pick = `WIN_EDGE;
        else if (h)
            pick = `WIN_HI;
        else if (l)
            pick = `WIN_LO;
        else if (g)
            pick = `WIN_GEN;
        else
            pick = `WIN_NONE;
    end
endfunction

// restart target for each winner
function [7:0] vec;
    input [2:0] w;
    begin
        case (w)
            `WIN_NMI: vec = `VEC_NMI;
            `WIN_EDGE: vec = `VEC_EDGE;
            `WIN_HI: vec = `VEC_HI;
            `WIN_LO: vec = `VEC_LO;
            default: vec = `VEC_NONE;
        endcase
    end
endfunction

// ********************************************
// pin synchronisers
// ********************************************
assign pin_w = {serial_in_line_i, nmi_request_i,
    restart_edge_i, restart_hi_i, restart_lo_i,
    general_int_request_i};

// a change counts once stages two and three agree
assign flt_nxt = (s2_r & s3_r) | (flt_r & (s2_r ^ s3_r));

// three flops per pin, then the agreed level
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        s1_r <= 6'h00;
        s2_r <= 6'h00;
        s3_r <= 6'h00;
        flt_r <= 6'h00;
    end
    else
    begin
        s1_r <= pin_w;
        s2_r <= s1_r;
        s3_r <= s2_r;
        flt_r <= flt_nxt;
    end
end

// rising edge of the filtered edge restart pin
assign edge_rise_w = flt_nxt[`PIN_EDGE] & ~flt_r[`PIN_EDGE];

// ********************************************
// pending terms
// ********************************************
// levels are plain high-active requests
assign gen_p = flt_r[`PIN_GEN] & ie_r;
assign lo_p = flt_r[`PIN_LO] & ie_r & ~mask_r[0];
assign hi_p = flt_r[`PIN_HI] & ie_r & ~mask_r[1];
assign edge_p = edge_ff_r & ie_r & ~mask_r[2];
// nmi bypasses enable and masks
assign nmi_p = flt_r[`PIN_NMI] & nmi_arm_r;
assign pick_w = pick(nmi_p, edge_p, hi_p, lo_p, gen_p);

// accept only once the instruction completes
assign accept_w = state_r[1] & instr_end_i;

// ********************************************
// wishbone decode
// ********************************************
assign req_w = wb_cyc_i & wb_stb_i & ~wb_ack_o;
assign wr_w = req_w & wb_we_i & wb_sel_i[0];
assign rd_w = req_w & ~wb_we_i;
assign set_w = wr_w & (wb_adr_i == `OFS_MASKSET);
assign get_w = rd_w & (wb_adr_i == `OFS_MASKREAD);
assign ena_w = wr_w & (wb_adr_i == `OFS_ENABLE);
// mask-set may ask to drop the edge request
assign edge_clr_w = set_w & wb_dat_i[`SET_EDGE_CLR];

// first read after nmi shows the saved enable
assign ie_report_w = nmi_seen_r ? ie_saved_r : ie_r;

// accept beats a software enable in one cycle
assign ie_nxt = accept_w ? 1'b0
    : (ena_w ? wb_dat_i[`ENA_IE] : ie_r);

// ********************************************
// sequencer
// ********************************************
// decision is made at the sample slot and held
// until the current instruction ends
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        state_r <= S_IDLE;
        win_r <= `WIN_NONE;
    end
    else
    begin
        case (state_r)
            S_IDLE:
            begin
                if (sample_slot_i && pick_w != `WIN_NONE)
                begin
                    win_r <= pick_w;
                    state_r <= S_WAIT;
                end
            end
            S_WAIT:
            begin
                if (instr_end_i)
                    state_r <= S_ACK;
                else if (sample_slot_i)
                begin
                    // halt or hold re-sample; may drop
                    win_r <= pick_w;
                    if (pick_w == `WIN_NONE)
                        state_r <= S_IDLE;
                end
            end
            S_ACK:
            begin
                if (ack_done_i)
                begin
                    state_r <= S_IDLE;
                    win_r <= `WIN_NONE;
                end
            end
            default:
            begin
                state_r <= S_IDLE;
                win_r <= `WIN_NONE;
            end
        endcase
    end
end

// ********************************************
// core steering outputs
// ********************************************
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        take_o <= 1'b0;
        push_pc_o <= 1'b0;
        restart_o <= 1'b0;
        vector_o <= `BYTE_ZERO;
        pc_inhibit_o <= 1'b0;
        int_acknowledge_strobe_o <= 1'b0;
    end
    else
    begin
        // one-cycle pulses on accept
        take_o <= accept_w;
        push_pc_o <= accept_w;
        if (accept_w)
        begin
            vector_o <= vec(win_r);
            restart_o <= (win_r != `WIN_GEN);
            pc_inhibit_o <= (win_r == `WIN_GEN);
        end
        else if (state_r[2] && ack_done_i)
        begin
            pc_inhibit_o <= 1'b0;
            restart_o <= 1'b0;
        end
        // strobe follows read timing one clock late;
        // restarts are inserted internally, no strobe
        int_acknowledge_strobe_o <= state_r[2] & ~ack_done_i
            & ack_rd_timing_i & (win_r == `WIN_GEN);
    end
end

// ********************************************
// enable, save and nmi arming
// ********************************************
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        ie_r <= 1'b0;
        ie_saved_r <= 1'b0;
        nmi_seen_r <= 1'b0;
        nmi_arm_r <= 1'b0;
    end
    else
    begin
        // global enable, cleared on accept
        ie_r <= ie_nxt;
        // nmi keeps the old enable for one read
        if (accept_w && win_r == `WIN_NMI)
        begin
            ie_saved_r <= ie_r;
            nmi_seen_r <= 1'b1;
        end
        else if (get_w)
            nmi_seen_r <= 1'b0;
        // re-arm only after the pin has gone low
        if (accept_w && win_r == `WIN_NMI)
            nmi_arm_r <= 1'b0;
        else if (!flt_r[`PIN_NMI])
            nmi_arm_r <= 1'b1;
    end
end

// ********************************************
// edge restart latch
// ********************************************
// set wins over take and mask-set clears, reset wins over set; sets even masked
always @(posedge clk_i)
begin
    if (rst_i)
        edge_ff_r <= 1'b0;
    else if (edge_rise_w)
        edge_ff_r <= 1'b1;
    else if ((accept_w && win_r == `WIN_EDGE) || edge_clr_w)
        edge_ff_r <= 1'b0;
end

// ********************************************
// masks and serial out
// ********************************************
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        mask_r <= `MASK_RST;
        sout_r <= 1'b0;
    end
    else if (set_w)
    begin
        // masks load only with their enable bit
        if (wb_dat_i[`SET_MASK_EN])
            mask_r <= wb_dat_i[`SET_MASK_HI:`SET_MASK_LO];
        if (wb_dat_i[`SET_SOUT_EN])
            sout_r <= wb_dat_i[`SET_SOUT];
    end
end

// ********************************************
// read mux
// ********************************************
always @*
begin
    rdat_nxt = `WORD_ZERO;
    case (wb_adr_i)
        `OFS_MASKSET:
        begin
            rdat_nxt[`SET_MASK_HI:`SET_MASK_LO] = mask_r;
            rdat_nxt[`SET_SOUT] = sout_r;
        end
        `OFS_MASKREAD:
        begin
            rdat_nxt[`SET_MASK_HI:`SET_MASK_LO] = mask_r;
            rdat_nxt[`GET_IE] = ie_report_w;
            rdat_nxt[`GET_PEND_LO] = flt_r[`PIN_LO];
            rdat_nxt[`GET_PEND_HI] = flt_r[`PIN_HI];
            rdat_nxt[`GET_PEND_EDGE] = edge_ff_r;
            rdat_nxt[`GET_SIN] = flt_r[`PIN_SIN];
        end
        `OFS_ENABLE:
            rdat_nxt[`ENA_IE] = ie_r;
        `OFS_STATUS:
            rdat_nxt[10:0] = {state_r, win_r, nmi_p, edge_p,
                hi_p, lo_p, gen_p};
        default:
            rdat_nxt = `WORD_ZERO; // unmapped reads zero
    endcase
end

// ********************************************
// bus answer
// ********************************************
// one wait state, every address answers
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= `WORD_ZERO;
    end
    else
    begin
        wb_ack_o <= req_w;
        if (rd_w)
            wb_dat_o <= rdat_nxt;
    end
end

// ********************************************
// pin-facing outputs
// ********************************************
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        int_enable_o <= 1'b0;
        serial_out_line_o <= 1'b0;
    end
    else
    begin
        // copy moves with the flag, so a take shows it low at once
        int_enable_o <= ie_nxt;
        serial_out_line_o <= sout_r;
    end
end

endmodule // cpu_priority_interrupt_unit

// ===== rtl/intc_map.vh
`ifndef INTC_MAP_VH
`define INTC_MAP_VH
// ********************************************
// register byte offsets, decoded on adr[3:0]
// ********************************************
`define OFS_MASKSET 4'h0
`define OFS_MASKREAD 4'h4
`define OFS_ENABLE 4'h8
`define OFS_STATUS 4'hc
// ********************************************
// mask-set word fields
// ********************************************
`define SET_MASK_LO 0
`define SET_MASK_HI 2
`define SET_MASK_EN 3
`define SET_EDGE_CLR 4
`define SET_SOUT_EN 6
`define SET_SOUT 7
// ********************************************
// mask-read word fields
// ********************************************
`define GET_IE 3
`define GET_PEND_LO 4
`define GET_PEND_HI 5
`define GET_PEND_EDGE 6
`define GET_SIN 7
// enable register field
`define ENA_IE 0
// ********************************************
// pin index inside the synchroniser vector
// ********************************************
`define PIN_GEN 0
`define PIN_LO 1
`define PIN_HI 2
`define PIN_EDGE 3
`define PIN_NMI 4
`define PIN_SIN 5
// ********************************************
// winner codes and restart vectors
// ********************************************
`define WIN_NONE 3'h0
`define WIN_NMI 3'h1
`define WIN_EDGE 3'h2
`define WIN_HI 3'h3
`define WIN_LO 3'h4
`define WIN_GEN 3'h5
`define VEC_NMI 8'h24
`define VEC_EDGE 8'h3c
`define VEC_HI 8'h34
`define VEC_LO 8'h2c
`define VEC_NONE 8'h00
// ********************************************
// reset values
// ********************************************
`define MASK_RST 3'h7
`define BYTE_ZERO 8'h00
`define WORD_ZERO 32'h0000_0000
`endif

// ===== dv/irq_checker.sv
`timescale 1ns/1ps
// ********
// steering and bus checks
// ********
module irq_checker
(
    // clock and reset
    input logic clk_i,
    input logic rst_i,
    // bus
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_ack_o,
    // core strobes
    input logic instr_end_i,
    input logic ack_rd_timing_i,
    // steering
    input logic take_o,
    input logic push_pc_o,
    input logic restart_o,
    input logic [7:0] vector_o,
    input logic pc_inhibit_o,
    input logic int_acknowledge_strobe_o,
    input logic int_enable_o,
    input logic serial_out_line_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // one ack, one cycle late, then dropped
    a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o ##1 !wb_ack_o) else $error("bus ack timing");
    a_push_with_take: assert property (take_o == push_pc_o)
        else $error("push not with take");
    a_take_after_end: assert property ($rose(take_o) |->
        $past(instr_end_i)) else $error("take not after end");
    a_take_drops_en: assert property (take_o |-> !int_enable_o)
        else $error("enable kept on take");
    a_restart_vec: assert property (take_o && restart_o |->
        vector_o inside {8'h24, 8'h3c, 8'h34, 8'h2c})
        else $error("bad vector");
    a_general_vec: assert property (take_o && !restart_o |->
        vector_o == 8'h00 && pc_inhibit_o) else $error("general steer");
    a_no_rst_strobe: assert property (restart_o |->
        !int_acknowledge_strobe_o) else $error("strobe on restart");
    a_strobe_lag: assert property (int_acknowledge_strobe_o |->
        $past(ack_rd_timing_i) && pc_inhibit_o) else $error("stray strobe");
    a_strobe_follows: assert property (pc_inhibit_o &&
        $past(pc_inhibit_o) && $past(ack_rd_timing_i)
        |-> int_acknowledge_strobe_o) else $error("strobe missing");
    a_steer_stable: assert property (restart_o && $past(restart_o)
        |-> $stable(vector_o)) else $error("vector moved");
    a_reset_clear: assert property ($past(rst_i) |-> !take_o &&
        !int_enable_o && !serial_out_line_o) else $error("reset state");
    // main scenarios reached
    c_restart: cover property (take_o && restart_o);
    c_general: cover property (take_o && !restart_o);
    c_strobe: cover property (int_acknowledge_strobe_o);
endmodule // irq_checker
bind cpu_priority_interrupt_unit irq_checker irq_checker_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .instr_end_i(instr_end_i),
    .ack_rd_timing_i(ack_rd_timing_i), .take_o(take_o),
    .push_pc_o(push_pc_o), .restart_o(restart_o), .vector_o(vector_o),
    .pc_inhibit_o(pc_inhibit_o),
    .int_acknowledge_strobe_o(int_acknowledge_strobe_o),
    .int_enable_o(int_enable_o), .serial_out_line_o(serial_out_line_o));

// ===== dv/core_timing_model.sv
`timescale 1ns/1ps
// ********
// core timing beside the unit
// ********
module core_timing_model
(
    // clock and reset
    input logic clk_i,
    input logic rst_i,
    // from the unit
    input logic take_i,
    input logic strobe_i,
    // timing strobes
    output logic sample_slot_o,
    output logic instr_end_o,
    output logic ack_rd_timing_o,
    output logic ack_done_o,
    // fetched ack instructions
    output logic [31:0] strobe_cnt_o
);
    logic [1:0] ph_r; // phase inside instruction or ack cycle
    logic in_ack_r; // ack machine cycle running
    logic strobe_r; // strobe edge finder
    // four-state loop; strobes come from flops so they move after edges
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ph_r <= 2'h0;
            in_ack_r <= 1'b0;
            strobe_r <= 1'b0;
            strobe_cnt_o <= 32'h0000_0000;
        end
        else
        begin
            strobe_r <= strobe_i;
            // one supplied instruction per strobe
            if (strobe_i && !strobe_r)
                strobe_cnt_o <= strobe_cnt_o + 1;
            if (take_i)
            begin
                in_ack_r <= 1'b1;
                ph_r <= 2'h0;
            end
            else
            begin
                ph_r <= ph_r + 2'h1;
                if (in_ack_r && ph_r == 2'h3)
                    in_ack_r <= 1'b0;
            end
        end
    end
    assign sample_slot_o = !in_ack_r && ph_r == 2'h2;
    assign instr_end_o = !in_ack_r && ph_r == 2'h3;
    assign ack_rd_timing_o = in_ack_r && ph_r == 2'h1;
    assign ack_done_o = in_ack_r && ph_r == 2'h3;
endmodule // core_timing_model

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
    // ********
    // signals
    // ********
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, sin = 0;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000, dat_o, q, scnt;
    logic [4:0] pin = 5'h00; // nmi, edge, high, low, general
    logic ack, slot, iend, rdt, adone, take, push, rso, pci, strb, ie, sout;
    logic [7:0] vec, last_vec;
    logic last_rst;
    integer fails = 0, num_checks = 0, takes = 0, seen = 0, i;
    cpu_priority_interrupt_unit cpu_priority_interrupt_unit_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .general_int_request_i(pin[0]),
        .restart_lo_i(pin[1]), .restart_hi_i(pin[2]),
        .restart_edge_i(pin[3]), .nmi_request_i(pin[4]),
        .serial_in_line_i(sin), .sample_slot_i(slot), .instr_end_i(iend),
        .ack_rd_timing_i(rdt), .ack_done_i(adone), .take_o(take),
        .push_pc_o(push), .restart_o(rso), .vector_o(vec),
        .pc_inhibit_o(pci), .int_acknowledge_strobe_o(strb),
        .int_enable_o(ie), .serial_out_line_o(sout));
    core_timing_model core_timing_model_i (
        .clk_i(clk_i), .rst_i(rst_i), .take_i(take), .strobe_i(strb),
        .sample_slot_o(slot), .instr_end_o(iend), .ack_rd_timing_o(rdt),
        .ack_done_o(adone), .strobe_cnt_o(scnt));
    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end
    // log every accepted interrupt
    always @(posedge clk_i)
    begin
        if (take === 1'b1)
        begin
            takes <= takes + 1;
            last_vec <= vec;
            last_rst <= rso;
        end
    end
    // ********
    // shared tasks
    // ********
    task chk(input logic [31:0] s, input logic [31:0] e);
        begin
            num_checks = num_checks + 1;
            if (s !== e)
            begin
                fails = fails + 1;
                $display("ERROR %0t: saw %h expected %h", $time, s, e);
            end
        end
    endtask
    // classic single cycle; s sets every byte enable
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d,
            input logic s);
        begin
            @(posedge clk_i);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            dat <= d;
            sel <= {4{s}};
            // wait for the answer; only the watchdog ends a hang
            do
            begin
                @(posedge clk_i);
            end
            while (ack !== 1'b1);
            q = dat_o;
            cyc <= 1'b0;
            stb <= 1'b0;
        end
    endtask
    task pins(input logic [4:0] v);
        begin
            @(posedge clk_i);
            pin <= v;
        end
    endtask
    // wait for the next take, then for the ack cycle to end
    task want(input logic [7:0] v);
        integer n;
        begin
            n = 0;
            while (takes == seen && n < 300)
            begin
                @(posedge clk_i);
                n = n + 1;
            end
            @(posedge clk_i);
            chk(takes > seen, 1);
            seen = takes;
            chk(last_vec, v);
            chk(last_rst, v != 8'h00);
            n = 0;
            while ((rso !== 1'b0 || pci !== 1'b0) && n < 50)
            begin
                @(posedge clk_i);
                n = n + 1;
            end
            chk({rso, pci}, 2'b00);
        end
    endtask
    // nothing may be taken for a while
    task quiet;
        integer t;
        begin
            t = takes;
            repeat (40) @(posedge clk_i);
            chk(takes, t);
        end
    endtask
    task pulse;
        begin
            pins(5'h08);
            repeat (4) @(posedge clk_i);
            pins(5'h00);
            repeat (8) @(posedge clk_i);
        end
    endtask
    // ********
    // scenarios
    // ********
    task t_reset;
        begin
            chk(ie, 0);
            wb(1'b0, 4'h4, 0, 1'b1);
            chk(q[3:0], 4'h7);
            wb(1'b0, 4'h8, 0, 1'b1);
            chk(q, 0);
            wb(1'b0, 4'hc, 0, 1'b1);
            chk(q, 32'h0000_0100);
            $display("t_reset done");
        end
    endtask
    // all five at once, taken one by one in fixed order
    task t_prio;
        begin
            wb(1'b1, 4'h0, 32'h0000_0008, 1'b1);
            wb(1'b1, 4'h8, 1, 1'b1);
            @(negedge clk_i);
            chk(ie, 1);
            pins(5'h1f);
            repeat (4) @(posedge clk_i);
            pins(5'h17);
            want(8'h24);
            pins(5'h07);
            wb(1'b0, 4'h4, 0, 1'b1);
            chk(q[3], 1);
            wb(1'b0, 4'h4, 0, 1'b1);
            chk(q[3], 0);
            wb(1'b1, 4'h8, 1, 1'b1);
            want(8'h3c);
            wb(1'b0, 4'h4, 0, 1'b1);
            chk({q[6], q[3]}, 0);
            wb(1'b1, 4'h8, 1, 1'b1);
            want(8'h34);
            pins(5'h03);
            repeat (8) @(posedge clk_i);
            wb(1'b1, 4'h8, 1, 1'b1);
            want(8'h2c);
            pins(5'h01);
            repeat (8) @(posedge clk_i);
            chk(scnt, 0);
            wb(1'b1, 4'h8, 1, 1'b1);
            want(8'h00);
            pins(5'h00);
            chk(scnt, 1);
            $display("t_prio done");
        end
    endtask
    task t_masked;
        begin
            wb(1'b1, 4'h0, 32'h0000_000f, 1'b1);
            wb(1'b1, 4'h8, 1, 1'b1);
            pulse;
            quiet;
            wb(1'b0, 4'h4, 0, 1'b1);
            chk(q[6], 1);
            wb(1'b1, 4'h0, 32'h0000_000b, 1'b1);
            want(8'h3c);
            wb(1'b1, 4'h0, 32'h0000_000f, 1'b1);
            wb(1'b1, 4'h8, 1, 1'b1);
            pulse;
            wb(1'b1, 4'h0, 32'h0000_001f, 1'b1);
            wb(1'b0, 4'h4, 0, 1'b1);
            chk(q[6], 0);
            wb(1'b1, 4'h0, 32'h0000_000b, 1'b1);
            quiet;
            $display("t_masked done");
        end
    endtask
    task t_nmi;
        begin
            wb(1'b1, 4'h8, 0, 1'b1);
            wb(1'b1, 4'h0, 32'h0000_0008, 1'b1);
            pins(5'h02);
            quiet;
            pins(5'h12);
            want(8'h24);
            quiet;
            pins(5'h02);
            repeat (8) @(posedge clk_i);
            pins(5'h12);
            want(8'h24);
            pins(5'h00);
            $display("t_nmi done");
        end
    endtask
    task t_serial;
        begin
            wb(1'b1, 4'h0, 32'h0000_00c0, 1'b1);
            @(negedge clk_i);
            chk(sout, 1);
            wb(1'b0, 4'h0, 0, 1'b1);
            chk(q, 32'h0000_0080);
            wb(1'b1, 4'h0, 32'h0000_0040, 1'b0);
            @(negedge clk_i);
            chk(sout, 1);
            wb(1'b1, 4'h0, 32'h0000_0040, 1'b1);
            @(negedge clk_i);
            chk(sout, 0);
            for (i = 1; i >= 0; i = i - 1)
            begin
                @(posedge clk_i);
                sin <= i[0];
                repeat (6) @(posedge clk_i);
                wb(1'b0, 4'h4, 0, 1'b1);
                chk(q[7], i[0]);
            end
            wb(1'b0, 4'h2, 0, 1'b1);
            chk(q, 0);
            $display("t_serial done");
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", num_checks, fails);
            if (fails == 0 && num_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // ********
    // main sequence
    // ********
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_prio;
        t_masked;
        t_nmi;
        t_serial;
        summarize;
    end
    // tests need a few hundred cycles; 40000 means a hang
    initial
    begin
        #1000000;
        fails = fails + 1;
        summarize;
    end
endmodule // tb
